// *** rtl/ipc_pkg.sv ***
// package: constants, register map and types of the interrupt priority controller
package ipc_pkg;
  // source count and widths
  localparam int NUM_SRC = 12;
  localparam int IDX_W = 4;
  localparam int PRIO_W = 3;
  localparam int LVL_W = 4;
  localparam int VEC_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int VADDR_W = 24;

  // irq number of each source slot, slot 11 first, slot 0 (external request 0) last
  localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_IRQ = {
    8'hB4, 8'hB3, 8'hB2, 8'hB1, 8'hAE, 8'hAD,
    8'hA4, 8'hA3, 8'hA2, 8'hA1, 8'hA0, 8'h00};
  localparam logic [VEC_W-1:0] VEC_OFFSET = 8'h08;
  localparam logic [VADDR_W-1:0] STD_TABLE_BASE = 24'h000004;
  localparam logic [VADDR_W-1:0] ALT_TABLE_BASE = 24'h000204;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_CTL1 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTL2 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CTL3 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CTL4 = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PEND = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] REG_CORE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_FLAG = 4'h8;
  localparam logic [ADDR_W-1:0] REG_ENAB = 4'h9;
  localparam logic [ADDR_W-1:0] REG_PRIO0 = 4'hA;
  localparam logic [ADDR_W-1:0] REG_PRIO2 = 4'hC;

  // field positions
  localparam int NEST_OFF_BIT = 15;
  localparam int GATE_BIT = 15;
  localparam int ALT_BIT = 8;
  localparam int EP0_BIT = 0;
  localparam int LVL_LO_POS = 5;
  localparam int TOP_BIT_POS = 3;
  localparam int NEW_LVL_POS = 8;

  // writable bits of each control word, hardware-set flag bits of control word 1
  localparam logic [DATA_W-1:0] CTL1_WMASK = 16'hFFDE;
  localparam logic [DATA_W-1:0] CTL1_FLAGS = 16'h78DE;
  localparam logic [DATA_W-1:0] CTL2_WMASK = 16'hE117;
  localparam logic [DATA_W-1:0] CTL3_WMASK = 16'h0111;
  localparam logic [DATA_W-1:0] CTL4_WMASK = 16'h0001;

  // values after reset
  localparam logic [DATA_W-1:0] CTL1_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CTL2_RST = 16'h8000;
  localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;
  localparam logic [PRIO_W-1:0] LVL_LO_RST = 3'h0;
  localparam logic [PRIO_W-1:0] LVL_LO_MAX = 3'h7;

  typedef logic [NUM_SRC-1:0][PRIO_W-1:0] ipc_prio_t;
endpackage

// *** rtl/ipc_res_if.sv ***
// interface: source state to the resolver and its winner back
interface ipc_res_if;
  import ipc_pkg::*;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enables;
  ipc_prio_t prio;
  logic win_valid;
  logic [IDX_W-1:0] win_idx;
  logic [PRIO_W-1:0] win_lvl;
  modport ctrl (output flags, enables, prio,
                input win_valid, win_idx, win_lvl);
  modport res (input flags, enables, prio,
               output win_valid, win_idx, win_lvl);
endinterface

// *** rtl/ipc_resolver.sv ***
// module: highest-priority pending source, lowest slot wins a tie
module ipc_resolver
  import ipc_pkg::*;
(
  ipc_res_if.res rif
);
  // descending scan with >= leaves the lowest slot among equals
  always_comb begin
    rif.win_valid = 1'b0;
    rif.win_idx = '0;
    rif.win_lvl = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (rif.flags[i] && rif.enables[i] && rif.prio[i] != '0 &&
          rif.prio[i] >= rif.win_lvl) begin
        rif.win_valid = 1'b1;
        rif.win_idx = IDX_W'(i);
        rif.win_lvl = rif.prio[i];
      end
    end
  end
endmodule

// *** rtl/ipc_ctrl.sv ***
// module: interrupt priority controller top with registers and gating
// Functional notes
// - one sticky request flag per source, set by hardware, cleared by software
// - one enable bit per source; disabled sources never reach the CPU
// - three-bit priority per source, levels 1 to 7, zero never interrupts
// - pending vector number and its level latched in a readable register
// - flags, enables, priorities laid out in vector order, ext 0 at bit 0
// - status word bits 7:5 hold low CPU level, software writable
// - fourth level bit in core control word is read-only to software
// - CPU level is top bit concatenated above the three status bits
// - level 7 or top bit set blocks all user interrupts
// - nesting disable makes status level bits read-only
// - nesting disable stops a running handler being pre-empted
// - global gate zero suppresses interrupts, traps still go; resets to one
// - alternate-table select moves vector fetches to the alternate table
// - external polarity one picks falling edge, zero rising edge
// - one control word holds edge polarity, global gate and table select
// - trap status flags recorded for software, incl. soft and hard traps
// - bus-collision sources sit at vectors 181 and 182
// - comparator and filter sources sit at vectors 185 to 188
//
// Chosen here: the address map and strobed register access.
module ipc_ctrl
  import ipc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [ipc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ipc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ipc_pkg::DATA_W-1:0] rdata_o,
  // request sources
  input wire logic external_request_0_i,
  input wire logic [ipc_pkg::NUM_SRC-2:0] periph_req_i,
  // trap status events
  input wire logic [ipc_pkg::DATA_W-1:0] trap_set_i,
  input wire logic [ipc_pkg::DATA_W-1:0] soft_trap_set_i,
  input wire logic sw_hard_trap_set_i,
  // cpu core side
  input wire logic cpu_level_top_bit_i,
  input wire logic cpu_ack_i,
  input wire logic handler_done_i,
  output logic irq_req_o,
  output logic [ipc_pkg::VEC_W-1:0] irq_vec_o,
  output logic [ipc_pkg::LVL_W-1:0] irq_level_o,
  output logic [ipc_pkg::VADDR_W-1:0] irq_vec_addr_o,
  output logic [ipc_pkg::LVL_W-1:0] cpu_level_o
);
  import ipc_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctl1;
    logic [DATA_W-1:0] ctl2;
    logic [DATA_W-1:0] ctl3;
    logic [DATA_W-1:0] ctl4;
    logic [PRIO_W-1:0] lvl_lo;
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] enables;
    ipc_prio_t prio;
    logic [VEC_W-1:0] pend_vec;
    logic [LVL_W-1:0] pend_lvl;
    logic in_handler;
    logic ext_prev;
    logic [DATA_W-1:0] rdata;
    logic irq_req;
    logic [VADDR_W-1:0] vec_addr;
  } ipc_state_t;

  ipc_state_t st;
  ipc_state_t next_st;
  ipc_res_if rif();

  logic [NUM_SRC-1:0] set_vec;
  logic ext_edge;
  logic [LVL_W-1:0] cpu_level;
  logic [LVL_W-1:0] cand_lvl;
  logic [VEC_W-1:0] cand_vec;
  logic present;
  logic [VADDR_W-1:0] cand_addr;

  // priority register k packs four sources, three bits at 4*j
  function automatic logic [DATA_W-1:0] prio_word(input ipc_prio_t p,
                                                  input int k);
    logic [DATA_W-1:0] w;
    w = '0;
    for (int j = 0; j < 4; j++) begin
      if (4 * k + j < NUM_SRC) begin
        w[4*j +: PRIO_W] = p[4*k+j];
      end
    end
    return w;
  endfunction

  // winner search lives in its own module
  ipc_resolver u_res (
    .rif(rif.res)
  );
  assign rif.flags = st.flags;
  assign rif.enables = st.enables;
  assign rif.prio = st.prio;

  // external input edge, polarity picked by its control bit
  assign ext_edge = st.ctl2[EP0_BIT] ?
                    (st.ext_prev && !external_request_0_i) :
                    (!st.ext_prev && external_request_0_i);
  assign set_vec = {periph_req_i, ext_edge};

  // cpu level is the top bit over the three status bits
  assign cpu_level = {cpu_level_top_bit_i, st.lvl_lo};
  assign cand_lvl = {1'b0, rif.win_lvl};
  assign cand_vec = SRC_IRQ[rif.win_idx] + VEC_OFFSET;
  assign cand_addr = (st.ctl2[ALT_BIT] ? ALT_TABLE_BASE : STD_TABLE_BASE) +
                     {15'h0000, cand_vec, 1'b0};

  // level compare also blocks level 7 and top bit set, since levels <= 7
  assign present = rif.win_valid && st.ctl2[GATE_BIT] &&
                   cand_lvl > cpu_level &&
                   !(st.ctl1[NEST_OFF_BIT] && st.in_handler);

  // next state: bus writes first, hardware sets on top so a set wins
  always_comb begin
    next_st = st;
    next_st.ext_prev = external_request_0_i;
    next_st.rdata = '0;
    if (wr_i) begin
      case (addr_i)
        REG_CTL1: next_st.ctl1 = wdata_i & CTL1_WMASK;
        REG_CTL2: next_st.ctl2 = wdata_i & CTL2_WMASK;
        REG_CTL3: next_st.ctl3 = wdata_i & CTL3_WMASK;
        REG_CTL4: next_st.ctl4 = wdata_i & CTL4_WMASK;
        REG_STAT: begin
          if (!st.ctl1[NEST_OFF_BIT]) begin
            next_st.lvl_lo = wdata_i[LVL_LO_POS +: PRIO_W];
          end
        end
        REG_FLAG: next_st.flags = wdata_i[NUM_SRC-1:0];
        REG_ENAB: next_st.enables = wdata_i[NUM_SRC-1:0];
        default: begin
          for (int k = 0; k < 3; k++) begin
            if (addr_i == REG_PRIO0 + ADDR_W'(k)) begin
              for (int j = 0; j < 4; j++) begin
                if (4 * k + j < NUM_SRC) begin
                  next_st.prio[4*k+j] = wdata_i[4*j +: PRIO_W];
                end
              end
            end
          end
        end
      endcase
    end
    // hardware sets override a same-cycle software clear
    next_st.flags = next_st.flags | set_vec;
    next_st.ctl1 = next_st.ctl1 | (trap_set_i & CTL1_FLAGS);
    next_st.ctl3 = next_st.ctl3 | (soft_trap_set_i & CTL3_WMASK);
    if (sw_hard_trap_set_i) begin
      next_st.ctl4[0] = 1'b1;
    end
    // cpu accept raises its level to the taken one
    if (cpu_ack_i && st.irq_req) begin
      next_st.lvl_lo = st.pend_lvl[PRIO_W-1:0];
      next_st.in_handler = 1'b1;
    end else if (handler_done_i) begin
      next_st.in_handler = 1'b0;
    end
    // latch the presented vector and its level
    next_st.irq_req = present;
    if (present) begin
      next_st.pend_vec = cand_vec;
      next_st.pend_lvl = cand_lvl;
      next_st.vec_addr = cand_addr;
    end
    // read data stand one cycle after the strobe
    if (rd_i) begin
      case (addr_i)
        REG_CTL1: next_st.rdata = st.ctl1;
        REG_CTL2: next_st.rdata = st.ctl2;
        REG_CTL3: next_st.rdata = st.ctl3;
        REG_CTL4: next_st.rdata = st.ctl4;
        REG_PEND: next_st.rdata = {4'h0, st.pend_lvl, st.pend_vec};
        REG_STAT: next_st.rdata = {8'h00, st.lvl_lo, 5'h00};
        REG_CORE: begin
          next_st.rdata = {12'h000, cpu_level_top_bit_i, 3'h0};
        end
        REG_FLAG: next_st.rdata = {4'h0, st.flags};
        REG_ENAB: next_st.rdata = {4'h0, st.enables};
        default: begin
          for (int k = 0; k < 3; k++) begin
            if (addr_i == REG_PRIO0 + ADDR_W'(k)) begin
              next_st.rdata = prio_word(st.prio, k);
            end
          end
        end
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctl1 <= CTL1_RST;
      st.ctl2 <= CTL2_RST;
      st.lvl_lo <= LVL_LO_RST;
      st.vec_addr <= STD_TABLE_BASE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops, except cpu_level_o whose top bit is cpu_level_top_bit_i
  assign rdata_o = st.rdata;
  assign irq_req_o = st.irq_req;
  assign irq_vec_o = st.pend_vec;
  assign irq_level_o = st.pend_lvl;
  assign irq_vec_addr_o = st.vec_addr;
  assign cpu_level_o = cpu_level;

  // checks beside the logic
  gate_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctl2[GATE_BIT] |=> !irq_req_o)
    else $error("request presented with global gate off");
  level_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cpu_level_top_bit_i || st.lvl_lo == LVL_LO_MAX) |=> !irq_req_o)
    else $error("request presented at blocked cpu level");
  above_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o |-> $past(cand_lvl) > $past(cpu_level))
    else $error("presented level not above cpu level");
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    set_vec[0] |=> st.flags[0])
    else $error("request flag lost its set");
  flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.flags[1] && !(wr_i && addr_i == REG_FLAG)) |=> st.flags[1])
    else $error("request flag dropped without software");
  enable_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.enables == '0) |=> !irq_req_o)
    else $error("request with all sources disabled");
  status_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctl1[NEST_OFF_BIT] && wr_i && addr_i == REG_STAT && !cpu_ack_i)
    |=> $stable(st.lvl_lo))
    else $error("status level written while nesting disabled");
  nest_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctl1[NEST_OFF_BIT] && st.in_handler) |=> !irq_req_o)
    else $error("handler pre-empted with nesting disabled");
  vec_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o && !$past(st.ctl2[ALT_BIT]) |->
    irq_vec_addr_o == STD_TABLE_BASE + {15'h0000, irq_vec_o, 1'b0})
    else $error("vector address mismatch");
  read_late_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == REG_PEND) |=>
    rdata_o == {4'h0, $past(st.pend_lvl), $past(st.pend_vec)})
    else $error("pending register read wrong");

  req_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o ##1 cpu_ack_i);
  alt_used_c: cover property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o && st.ctl2[ALT_BIT]);
  fall_edge_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ext_edge && st.ctl2[EP0_BIT]);
endmodule

// *** sim/ipc_cpu_model.sv ***
// cpu core stand-in: takes presented requests, later ends the handler
module ipc_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // controller side
  input wire logic irq_req_i,
  input wire logic en_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic busy;
  // one ack per request after a short or long wait, done much later
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    done_o <= 1'b0;
    if (rst_i) begin
      cnt <= 0;
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == 60) begin
        done_o <= 1'b1; // handler ends, nesting open again
        busy <= 1'b0;
      end
    end else if (en_i && irq_req_i) begin
      cnt <= cnt + 1;
      if (cnt >= (slow_i ? 6 : 1)) begin
        ack_o <= 1'b1; // core level follows taken request
        busy <= 1'b1;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

// *** sim/tb.sv ***
// self-checking bench of the interrupt priority controller
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((e) !== (g)) begin \
    failures++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ipc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0, rdata_o;
  logic [DATA_W-1:0] trap_set_i = '0, soft_trap_set_i = '0;
  logic wr_i = 1'b0, rd_i = 1'b0, sw_hard_trap_set_i = 1'b0;
  logic external_request_0_i = 1'b0, cpu_level_top_bit_i = 1'b0;
  logic [NUM_SRC-2:0] periph_req_i = '0;
  logic cpu_ack_i, handler_done_i, irq_req_o, en_m = 1'b0, slow_m = 1'b0;
  logic [VEC_W-1:0] irq_vec_o;
  logic [LVL_W-1:0] irq_level_o, cpu_level_o;
  logic [VADDR_W-1:0] irq_vec_addr_o;
  int failures = 0, cmp_count = 0, seed = 20657;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  ipc_ctrl u_ipc_ctrl (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .external_request_0_i, .periph_req_i, .trap_set_i,
    .soft_trap_set_i, .sw_hard_trap_set_i, .cpu_level_top_bit_i,
    .cpu_ack_i, .handler_done_i, .irq_req_o, .irq_vec_o, .irq_level_o,
    .irq_vec_addr_o, .cpu_level_o);
  ipc_cpu_model u_ipc_cpu_model (.clk_i, .rst_i, .irq_req_i(irq_req_o),
    .en_i(en_m), .slow_i(slow_m), .ack_o(cpu_ack_i),
    .done_o(handler_done_i));
  task automatic print_verdict;
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // expected vector and table entry, worked out from the rules
  function automatic logic [VEC_W-1:0] exp_vec(input int k);
    return SRC_IRQ[k] + VEC_OFFSET;
  endfunction
  function automatic logic [VADDR_W-1:0] exp_addr(
    input logic [VEC_W-1:0] vec, input logic alt);
    return 24'h000004 + (alt ? 24'h000200 : 24'h000000) + 24'(2 * vec);
  endfunction
  // register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // slot 0 toggles away from its idle level and back, others pulse
  task automatic fire(input int k);
    @(posedge clk_i);
    if (k == 0) external_request_0_i <= ~external_request_0_i;
    else periph_req_i[k-1] <= 1'b1;
    @(posedge clk_i);
    if (k == 0) external_request_0_i <= ~external_request_0_i;
    else periph_req_i <= '0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // one source set up alone, fired, and its presentation judged
  task automatic trial(input int k, p, l, input logic alt, pol, en, g);
    logic [DATA_W-1:0] v;
    logic [VEC_W-1:0] vec;
    logic exp;
    vec = exp_vec(k);
    @(posedge clk_i);
    // taken after the edge so a top bit driven just before is seen
    exp = en && g && (p > l) && !cpu_level_top_bit_i;
    external_request_0_i <= pol;
    wr(REG_CTL2, {g, 6'h00, alt, 7'h00, pol});
    for (int i = 0; i < 3; i++) wr(REG_PRIO0 + ADDR_W'(i), ZERO16);
    wr(REG_PRIO0 + ADDR_W'(k / 4), DATA_W'(p) << (4 * (k % 4)));
    wr(REG_ENAB, DATA_W'(en) << k);
    wr(REG_STAT, DATA_W'(l) << LVL_LO_POS);
    wr(REG_FLAG, ZERO16);
    fire(k);
    settle();
    `CHK("cpu_level", {cpu_level_top_bit_i, 3'(l)}, cpu_level_o)
    `CHK("irq_req", exp, irq_req_o)
    rd(REG_FLAG, v);
    `CHK("flag", DATA_W'(1) << k, v)
    if (exp) begin
      `CHK("vec", vec, irq_vec_o)
      `CHK("lvl", LVL_W'(p), irq_level_o)
      `CHK("addr", exp_addr(vec, alt), irq_vec_addr_o)
      rd(REG_PEND, v);
      `CHK("pend", {4'h0, LVL_W'(p), vec}, v)
    end
  endtask
  initial begin
    #1000000;
    failures++;
    print_verdict();
  end
  initial begin
    logic [DATA_W-1:0] v;
    logic [31:0] r;
    int i;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_CTL2, v);
    `CHK("ctl2_rst", CTL2_RST, v)
    rd(4'h7, v);
    `CHK("unmapped", ZERO16, v)
    wr(REG_CORE, 16'h0008);
    rd(REG_CORE, v);
    `CHK("core_ro", ZERO16, v)
    // corner cases: both edges, table ends, level 7, gate off
    trial(0, 5, 2, 1'b0, 1'b0, 1'b1, 1'b1);
    trial(0, 5, 2, 1'b1, 1'b1, 1'b1, 1'b1);
    trial(6, 1, 0, 1'b0, 1'b0, 1'b1, 1'b1);
    trial(11, 7, 6, 1'b1, 1'b0, 1'b1, 1'b1);
    trial(8, 7, 7, 1'b0, 1'b0, 1'b1, 1'b1);
    trial(3, 6, 2, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk_i);
    cpu_level_top_bit_i <= 1'b1;
    trial(2, 7, 0, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(REG_CORE, v);
    `CHK("core_top", 16'h0008, v)
    @(posedge clk_i);
    cpu_level_top_bit_i <= 1'b0;
    // equal levels: the lower slot must win
    trial(6, 4, 0, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(REG_PRIO2, 16'h0004);
    wr(REG_ENAB, 16'h0140);
    fire(8);
    settle();
    `CHK("tie", exp_vec(6), irq_vec_o)
    // trap status flags, random pattern under each mask
    r = $random(seed);
    @(posedge clk_i);
    trap_set_i <= r[15:0];
    soft_trap_set_i <= r[31:16];
    sw_hard_trap_set_i <= 1'b1;
    @(posedge clk_i);
    trap_set_i <= '0;
    soft_trap_set_i <= '0;
    sw_hard_trap_set_i <= 1'b0;
    rd(REG_CTL1, v);
    `CHK("traps", r[15:0] & CTL1_FLAGS, v)
    rd(REG_CTL3, v);
    `CHK("soft", r[31:16] & CTL3_WMASK, v)
    rd(REG_CTL4, v);
    `CHK("hard", 16'h0001, v)
    // trap flags go away only when software writes zero
    wr(REG_CTL3, ZERO16);
    wr(REG_CTL4, ZERO16);
    rd(REG_CTL3, v);
    `CHK("soft_clr", ZERO16, v)
    rd(REG_CTL4, v);
    `CHK("hard_clr", ZERO16, v)
    // taken handler at level 3 must not be pre-empted while nesting is off
    trial(1, 3, 0, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(REG_CTL1, 16'h8000);
    slow_m <= r[0];
    en_m <= 1'b1;
    for (i = 0; i < 20 && cpu_ack_i !== 1'b1; i++) @(posedge clk_i) #1;
    en_m <= 1'b0;
    `CHK("ack", 1'b1, cpu_ack_i)
    if (cpu_ack_i !== 1'b1) print_verdict();
    settle();
    `CHK("taken_lvl", 4'h3, cpu_level_o)
    wr(REG_STAT, ZERO16);
    settle();
    `CHK("stat_ro", 4'h3, cpu_level_o)
    rd(REG_STAT, v);
    `CHK("stat_rd", 16'h0060, v)
    wr(REG_PRIO0, 16'h0530);
    wr(REG_ENAB, 16'h0006);
    fire(2);
    settle();
    `CHK("no_nest", 1'b0, irq_req_o)
    for (i = 0; i < 100 && handler_done_i !== 1'b1; i++) @(posedge clk_i) #1;
    // handler never ended: count it and close the run
    if (handler_done_i !== 1'b1) begin
      failures++;
      print_verdict();
    end
    settle();
    `CHK("after_done", 1'b1, irq_req_o)
    `CHK("after_vec", exp_vec(2), irq_vec_o)
    wr(REG_CTL1, ZERO16);
    // random sources, levels, tables, polarities, enables and gate
    for (int n = 0; n < 30; n++) begin
      r = $random(seed);
      trial(int'(r[3:0]) % NUM_SRC, int'(r[6:4]), int'(r[9:7]), r[10],
        r[11], r[13:12] != 2'h0, r[15:14] != 2'h0);
    end
    print_verdict();
  end
endmodule
